// [hdl/pmcs_map.svh]
`ifndef PMCS_MAP_SVH
`define PMCS_MAP_SVH

// Clock-select encodings.
`define PMCS_SEL_SEC    2'h1
`define PMCS_SEL_PRI    2'h2
`define PMCS_SEL_INT    2'h3

// Field positions in the oscillator control view.
`define PMCS_IDLE_BIT   7
`define PMCS_PACT_BIT   3
`define PMCS_SEL_HI     1
`define PMCS_SEL_LO     0

// Source-cycle counts for a switch and for primary start-up.
`define PMCS_OLD_CYC    2
`define PMCS_NEW_CYC    4
`define PMCS_OST_CYC    1024
`define PMCS_CNT_W      11

`endif

// [hdl/pmcs_pkg.sv]
package pmcs_pkg;

    typedef enum logic [3:0] {
        PMCS_BOOT,
        PMCS_RUN,
        PMCS_WAIT_PRI,
        PMCS_WAIT_SEC,
        PMCS_SW_OLD,
        PMCS_SW_NEW,
        PMCS_IDLE,
        PMCS_SLEEP,
        PMCS_WAKE
    } pmcs_mode_t;

    typedef struct packed {
        pmcs_mode_t  mode;
        logic [1:0]  cur_src;
        logic [1:0]  tgt_src;
        logic        pri_act;
        logic        sec_act;
        logic        pri_en;
        logic        int_en;
        logic        sec_en;
        logic        cpu_tick;
        logic        per_tick;
        logic [7:0]  osc_reg;
    } pmcs_state_t;

endpackage

// [hdl/pmcs_tick_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module pmcs_tick_counter #(
    parameter int W = 11
) (
    input  wire logic         clock,   // System clock.
    input  wire logic         nrst,    // Async reset, active low.
    input  wire logic         clear,   // Holds the count at zero.
    input  wire logic         tick,    // One source cycle.
    input  wire logic [W-1:0] target,  // Cycles to count.
    output logic              done     // Target reached, sticky.
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } pmcs_cnt_state_t;

    pmcs_cnt_state_t s_r;
    pmcs_cnt_state_t s_nxt;

    // Counting stops at the target so a long wait cannot wrap back to zero.
    always_comb begin
        s_nxt = s_r;
        if (clear) begin
            s_nxt = '0;
        end else if (tick && !s_r.done) begin
            s_nxt.cnt  = s_r.cnt + 1'b1;
            s_nxt.done = (s_nxt.cnt == target);
        end
    end

    // State register.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
endmodule
`default_nettype wire

// [hdl/pmcs_switch.sv]
// What this block does
// RL1 - A new clock-select value switches to that source at once if it oscillates.
// RL2 - Sleep instruction enters Sleep, or the selected Idle mode when idle-on-sleep set.
// RL3 - Select 10 primary, 01 secondary, 11 internal; Idle gates CPU only.
// RL4 - Sleep stops every CPU and peripheral clock; no source is used.
// RL5 - A switch takes two outgoing plus four incoming source cycles.
// RL6 - Flags show primary or secondary as source; both clear for internal.
// RL7 - Each sleep instruction samples idle-on-sleep when it executes.
// RL8 - After reset run from primary with primary flag set, unless two-speed start.
// RL9 - Selecting secondary switches to it, stops primary, updates both flags.
// RL10 - Selecting secondary with its oscillator disabled does not enter secondary run.
// RL11 - Secondary enabled but not oscillating withholds device clocks until it starts.
// RL12 - Secondary to primary keeps secondary clocking until primary ready, then flags swap.
// RL13 - Selecting internal switches to it, stops primary, clears primary flag.
// RL14 - Internal to primary keeps internal clocking until primary ready, then flag set.
// RL15 - Internal oscillator stays on when watchdog or clock monitor is enabled.
// RL16 - Sleep with idle-on-sleep clear stops the oscillator and clears all flags.
// RL17 - In Sleep, internal runs for watchdog, secondary runs when enabled.
// RL18 - Wake from Sleep withholds clocks until ready, or runs internal if enabled.
// RL19 - Idle-on-sleep is control bit 7, clock-select bits 1 to 0.
// RL20 - In crystal mode primary is ready after 1024 counted primary cycles.
// RL21 - Source changes pass only whole source cycles, never a shortened phase.
`timescale 1ns/1ps
`default_nettype none
`include "pmcs_map.svh"
module pmcs_switch
    import pmcs_pkg::*;
#(
    parameter int OLD_CYC = `PMCS_OLD_CYC,
    parameter int NEW_CYC = `PMCS_NEW_CYC,
    parameter int OST_CYC = `PMCS_OST_CYC
) (
    input  wire logic       clock,                  // System clock, 125 MHz.
    input  wire logic       nrst,                   // Async reset, active low.
    input  wire logic [1:0] clock_select,           // Software clock-select field.
    input  wire logic       idle_on_sleep,          // Software idle-on-sleep bit.
    input  wire logic       sleep_exec,             // Sleep instruction, one-cycle pulse.
    input  wire logic       wake_event,             // Interrupt, watchdog or reset wake pulse.
    input  wire logic       secondary_osc_enable,   // Secondary oscillator enable bit.
    input  wire logic       sec_osc_running,        // Secondary is oscillating.
    input  wire logic       pri_tick,               // One primary source cycle.
    input  wire logic       sec_tick,               // One secondary source cycle.
    input  wire logic       int_tick,               // One internal source cycle.
    input  wire logic       crystal_mode,           // Primary needs a start-up count.
    input  wire logic       two_speed_en,           // Two-speed start-up enabled.
    input  wire logic       fscm_en,                // Fail-safe clock monitor enabled.
    input  wire logic       wdt_en,                 // Watchdog enabled.
    output logic            cpu_clk_tick,           // Gated CPU clock cycle.
    output logic            periph_clk_tick,        // Gated peripheral clock cycle.
    output logic [1:0]      active_src,             // Source now clocking the device.
    output logic            pri_osc_en,             // Primary oscillator enable.
    output logic            sec_osc_en,             // Secondary oscillator enable.
    output logic            int_osc_en,             // Internal oscillator enable.
    output logic            primary_clock_active,   // Primary drives the clock.
    output logic            secondary_clock_active, // Secondary drives the clock.
    output logic [7:0]      osc_control_reg         // Control and status view.
);
    localparam logic [`PMCS_CNT_W-1:0] OLD_T = `PMCS_CNT_W'(OLD_CYC);
    localparam logic [`PMCS_CNT_W-1:0] NEW_T = `PMCS_CNT_W'(NEW_CYC);
    localparam logic [`PMCS_CNT_W-1:0] OST_T = `PMCS_CNT_W'(OST_CYC);

    pmcs_state_t s_r;
    pmcs_state_t s_nxt;
    logic        old_done;
    logic        new_done;
    logic        ost_done;
    logic        pri_ready;

    // Picks the cycle strobe of one source.
    function automatic logic src_tick(input logic [1:0] src,
                                      input logic p, input logic q, input logic i);
        logic t;
        t = 1'b0;
        case (src)
            `PMCS_SEL_PRI: t = p;
            `PMCS_SEL_SEC: t = q;
            `PMCS_SEL_INT: t = i;
            default:       t = 1'b0;
        endcase
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle counters: outgoing, incoming and primary start-up.

    pmcs_tick_counter #(.W(`PMCS_CNT_W)) u_old (
        .clock  (clock),
        .nrst   (nrst),
        .clear  (s_r.mode != PMCS_SW_OLD),
        .tick   (src_tick(s_r.cur_src, pri_tick, sec_tick, int_tick)),
        .target (OLD_T),
        .done   (old_done)
    );

    pmcs_tick_counter #(.W(`PMCS_CNT_W)) u_new (
        .clock  (clock),
        .nrst   (nrst),
        .clear  (s_r.mode != PMCS_SW_NEW),
        .tick   (src_tick(s_r.tgt_src, pri_tick, sec_tick, int_tick)),
        .target (NEW_T),
        .done   (new_done)
    );

    // The start-up count restarts whenever the primary is switched off.
    pmcs_tick_counter #(.W(`PMCS_CNT_W)) u_ost (
        .clock  (clock),
        .nrst   (nrst),
        .clear  (!s_r.pri_en),
        .tick   (pri_tick),
        .target (OST_T),
        .done   (ost_done)
    );

    // An external clock is taken as ready as soon as it is enabled.
    assign pri_ready = s_r.pri_en && (ost_done || !crystal_mode); // RL20

    ////////////////////////////////////////////////////////////////////////////////
    // Mode sequencer.

    always_comb begin
        s_nxt = s_r;
        case (s_r.mode)
            PMCS_BOOT: begin
                if (two_speed_en) begin
                    s_nxt.cur_src = `PMCS_SEL_INT;
                    s_nxt.tgt_src = `PMCS_SEL_PRI;
                    s_nxt.mode    = PMCS_WAIT_PRI;
                end else begin
                    s_nxt.mode = PMCS_RUN; // RL8
                end
            end
            PMCS_RUN: begin
                if (sleep_exec && !idle_on_sleep) begin
                    s_nxt.tgt_src = clock_select;
                    s_nxt.mode    = PMCS_SLEEP; // RL2 RL7 RL16
                end else if (clock_select != s_r.cur_src) begin
                    // A pending switch wins over an idle request for another source.
                    s_nxt.tgt_src = clock_select;
                    case (clock_select)
                        `PMCS_SEL_PRI: s_nxt.mode = PMCS_WAIT_PRI; // RL12 RL14
                        `PMCS_SEL_INT: s_nxt.mode = PMCS_SW_OLD;   // RL1 RL13
                        `PMCS_SEL_SEC: begin
                            if (!secondary_osc_enable) begin
                                s_nxt.tgt_src = s_r.cur_src; // RL10
                            end else if (sec_osc_running) begin
                                s_nxt.mode = PMCS_SW_OLD; // RL1 RL9
                            end else begin
                                s_nxt.mode = PMCS_WAIT_SEC; // RL11
                            end
                        end
                        default: s_nxt.tgt_src = s_r.cur_src;
                    endcase
                end else if (sleep_exec) begin
                    // Idle on a disabled secondary is refused outright.
                    if (!(s_r.cur_src == `PMCS_SEL_SEC && !secondary_osc_enable)) begin
                        s_nxt.mode = PMCS_IDLE; // RL2 RL7
                    end
                end
            end
            PMCS_WAIT_PRI: begin
                // Old source keeps clocking while the primary starts up.
                if (clock_select != `PMCS_SEL_PRI) begin
                    s_nxt.tgt_src = s_r.cur_src;
                    s_nxt.mode    = PMCS_RUN;
                end else if (pri_ready) begin
                    s_nxt.mode = PMCS_SW_OLD; // RL12 RL14
                end
            end
            PMCS_WAIT_SEC: begin
                if (!secondary_osc_enable) begin
                    s_nxt.tgt_src = s_r.cur_src;
                    s_nxt.mode    = PMCS_RUN;
                end else if (sec_osc_running) begin
                    s_nxt.mode = PMCS_SW_OLD; // RL11
                end
            end
            PMCS_SW_OLD: begin
                if (old_done) begin
                    s_nxt.mode = PMCS_SW_NEW; // RL5
                end
            end
            PMCS_SW_NEW: begin
                if (new_done) begin
                    s_nxt.cur_src = s_r.tgt_src; // RL5 RL9 RL13
                    s_nxt.mode    = PMCS_RUN;
                end
            end
            PMCS_IDLE: begin
                if (wake_event) begin
                    s_nxt.mode = PMCS_RUN;
                end
            end
            PMCS_SLEEP: begin
                if (wake_event) begin
                    s_nxt.tgt_src = clock_select;
                    if (two_speed_en || fscm_en) begin
                        // Run on internal at once; RUN then starts any switch.
                        s_nxt.cur_src = `PMCS_SEL_INT; // RL18
                        s_nxt.mode    = PMCS_RUN;
                    end else begin
                        s_nxt.mode = PMCS_WAKE; // RL18
                    end
                end
            end
            PMCS_WAKE: begin
                if ((s_r.tgt_src == `PMCS_SEL_PRI && pri_ready) ||
                    (s_r.tgt_src == `PMCS_SEL_SEC && sec_osc_running) ||
                    (s_r.tgt_src == `PMCS_SEL_INT)) begin
                    s_nxt.cur_src = s_r.tgt_src; // RL18
                    s_nxt.mode    = PMCS_RUN;
                end
            end
            default: s_nxt.mode = PMCS_RUN;
        endcase

        // Flags follow the source only once a switch has completed.
        if (s_nxt.mode == PMCS_SLEEP || s_nxt.mode == PMCS_WAKE) begin
            s_nxt.pri_act = 1'b0; // RL16
            s_nxt.sec_act = 1'b0;
        end else begin
            s_nxt.pri_act = (s_nxt.cur_src == `PMCS_SEL_PRI); // RL6 RL12 RL14
            s_nxt.sec_act = (s_nxt.cur_src == `PMCS_SEL_SEC); // RL6 RL9
        end

        // Primary runs only while in use or being started; Sleep stops it.
        s_nxt.pri_en = (s_nxt.mode != PMCS_SLEEP) &&
                       (s_nxt.cur_src == `PMCS_SEL_PRI ||
                        s_nxt.tgt_src == `PMCS_SEL_PRI); // RL4 RL9 RL13
        s_nxt.int_en = wdt_en || fscm_en || (s_nxt.mode != PMCS_SLEEP &&
                       (s_nxt.cur_src == `PMCS_SEL_INT ||
                        s_nxt.tgt_src == `PMCS_SEL_INT)); // RL15 RL17
        s_nxt.sec_en = secondary_osc_enable; // RL12 RL17

        // Gates open only on whole cycles of a settled source.
        s_nxt.cpu_tick = (s_r.mode == PMCS_RUN || s_r.mode == PMCS_WAIT_PRI ||
                          s_r.mode == PMCS_BOOT) &&
                         src_tick(s_r.cur_src, pri_tick, sec_tick, int_tick); // RL3 RL21
        s_nxt.per_tick = (s_r.mode == PMCS_RUN || s_r.mode == PMCS_WAIT_PRI ||
                          s_r.mode == PMCS_BOOT || s_r.mode == PMCS_IDLE) &&
                         src_tick(s_r.cur_src, pri_tick, sec_tick, int_tick); // RL3 RL21

        s_nxt.osc_reg                              = '0;
        s_nxt.osc_reg[`PMCS_IDLE_BIT]              = idle_on_sleep; // RL19
        s_nxt.osc_reg[`PMCS_PACT_BIT]              = s_nxt.pri_act;
        s_nxt.osc_reg[`PMCS_SEL_HI:`PMCS_SEL_LO]   = clock_select;
    end

    // State register; reset comes up running from the primary.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r         <= '0;
            s_r.mode    <= PMCS_BOOT;
            s_r.cur_src <= `PMCS_SEL_PRI;
            s_r.tgt_src <= `PMCS_SEL_PRI;
            s_r.pri_act <= 1'b1; // RL8
            s_r.pri_en  <= 1'b1;
            // The status view must show the primary flag from reset on.
            s_r.osc_reg[`PMCS_PACT_BIT] <= 1'b1; // RL8
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cpu_clk_tick           = s_r.cpu_tick;
    assign periph_clk_tick        = s_r.per_tick;
    assign active_src             = s_r.cur_src;
    assign pri_osc_en             = s_r.pri_en;
    assign sec_osc_en             = s_r.sec_en;
    assign int_osc_en             = s_r.int_en;
    assign primary_clock_active   = s_r.pri_act;
    assign secondary_clock_active = s_r.sec_act;
    assign osc_control_reg        = s_r.osc_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_sleep_gates;
        @(posedge clock) disable iff (!nrst)
        s_r.mode == PMCS_SLEEP |=> !cpu_clk_tick && !periph_clk_tick;
    endproperty
    a_sleep_gates: assert property (p_sleep_gates) else $error("clock in sleep"); // RL4

    property p_sleep_flags;
        @(posedge clock) disable iff (!nrst)
        s_r.mode == PMCS_RUN && sleep_exec && !idle_on_sleep
        |=> !primary_clock_active && !secondary_clock_active && !pri_osc_en;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags"); // RL16

    property p_idle_cpu;
        @(posedge clock) disable iff (!nrst)
        s_r.mode == PMCS_IDLE |=> !cpu_clk_tick;
    endproperty
    a_idle_cpu: assert property (p_idle_cpu) else $error("cpu clocked in idle"); // RL3

    property p_flag_excl;
        @(posedge clock) disable iff (!nrst)
        !(primary_clock_active && secondary_clock_active);
    endproperty
    a_flag_excl: assert property (p_flag_excl) else $error("both flags set"); // RL6

    property p_sec_refused;
        @(posedge clock) disable iff (!nrst)
        s_r.mode == PMCS_RUN && s_r.cur_src != `PMCS_SEL_SEC &&
        clock_select == `PMCS_SEL_SEC && !secondary_osc_enable && !sleep_exec
        |=> s_r.mode == PMCS_RUN;
    endproperty
    a_sec_refused: assert property (p_sec_refused) else $error("disabled sec"); // RL10

    property p_sec_wait;
        @(posedge clock) disable iff (!nrst)
        s_r.mode == PMCS_WAIT_SEC |=> !cpu_clk_tick && !periph_clk_tick;
    endproperty
    a_sec_wait: assert property (p_sec_wait) else $error("clock before sec"); // RL11

    property p_keep_old;
        @(posedge clock) disable iff (!nrst)
        s_r.mode == PMCS_WAIT_PRI &&
        src_tick(s_r.cur_src, pri_tick, sec_tick, int_tick) |=> periph_clk_tick;
    endproperty
    a_keep_old: assert property (p_keep_old) else $error("old clock lost"); // RL12

    property p_switch_done;
        @(posedge clock) disable iff (!nrst)
        s_r.mode == PMCS_SW_NEW && new_done
        |=> s_r.mode == PMCS_RUN && active_src == $past(s_r.tgt_src);
    endproperty
    a_switch_done: assert property (p_switch_done) else $error("switch end"); // RL5

    property p_idle_entry;
        @(posedge clock) disable iff (!nrst)
        s_r.mode == PMCS_RUN && sleep_exec && idle_on_sleep &&
        clock_select == s_r.cur_src && s_r.cur_src != `PMCS_SEL_SEC
        |=> s_r.mode == PMCS_IDLE;
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle not entered"); // RL7

    property p_lf_on;
        @(posedge clock) disable iff (!nrst)
        wdt_en || fscm_en |=> int_osc_en;
    endproperty
    a_lf_on: assert property (p_lf_on) else $error("internal osc off"); // RL15

    property p_ost_clear;
        @(posedge clock) disable iff (!nrst)
        !s_r.pri_en |=> !ost_done;
    endproperty
    a_ost_clear: assert property (p_ost_clear) else $error("start count kept"); // RL20

    c_idle:   cover property (@(posedge clock) disable iff (!nrst)
                              s_r.mode == PMCS_IDLE ##1 s_r.mode == PMCS_RUN);
    c_wake:   cover property (@(posedge clock) disable iff (!nrst)
                              s_r.mode == PMCS_WAKE ##1 s_r.mode == PMCS_RUN);
    c_switch: cover property (@(posedge clock) disable iff (!nrst)
                              s_r.mode == PMCS_SW_NEW ##1 s_r.mode == PMCS_RUN);
endmodule
`default_nettype wire

// [tb/pmcs_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pmcs_osc_model #(
    parameter int SEC_START = 20 // Secondary start-up cycles.
) (
    input  wire logic clock,    // System clock.
    input  wire logic nrst,     // Async reset, active low.
    input  wire logic pri_en,   // Primary oscillator enable.
    input  wire logic sec_en,   // Secondary oscillator enable bit.
    input  wire logic int_en,   // Internal oscillator enable.
    output logic      pri_tick, // One primary cycle.
    output logic      sec_tick, // One secondary cycle.
    output logic      int_tick, // One internal cycle.
    output logic      secondary_run_mode   // Secondary is oscillating.
);
    logic [2:0] div_r;
    logic [5:0] st_r;
    // A slow crystal: it only counts as running after a start-up delay.
    assign secondary_run_mode = (st_r == 6'(SEC_START));
    // Sources tick only while enabled, so a stopped oscillator shows no edges.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_r <= 3'h0;
            st_r <= 6'h00;
            pri_tick <= 1'b0;
            sec_tick <= 1'b0;
            int_tick <= 1'b0;
        end else begin
            div_r <= div_r + 3'h1;
            if (!sec_en) begin
                st_r <= 6'h00;
            end else if (!secondary_run_mode) begin
                st_r <= st_r + 6'h01;
            end
            pri_tick <= pri_en & div_r[0];
            sec_tick <= secondary_run_mode & (div_r[1:0] == 2'h3);
            int_tick <= int_en & (div_r == 3'h7);
        end
    end
endmodule
`default_nettype wire

// [tb/tb_pmcs_switch.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_pmcs_switch;
    localparam int OSC_STARTUP_TIMER = 8;
    localparam int SEC_ST = 20;
    logic       clock = 1'b0;
    logic       nrst = 1'b0;
    logic [1:0] clock_select = 2'h2;
    logic       idle_on_sleep = 1'b0;
    logic       sleep_exec = 1'b0;
    logic       wake_event = 1'b0;
    logic       sec_bit = 1'b0;
    logic       crystal_mode = 1'b1;
    logic       two_speed_en = 1'b0;
    logic       fscm_en = 1'b0;
    logic       wdt_en = 1'b1;
    logic       pri_tick, sec_tick, int_tick, secondary_run_mode;
    logic       cpu_tick, per_tick, pri_en, sec_en, int_en, pact, sact;
    logic [1:0] active_src;
    logic [7:0] oreg;
    int         failures = 0;
    int         total_checks = 0;
    // Four-state counters, so an unknown tick poisons the count.
    integer     n_cyc, n_cpu, n_per;
    // Free-running system clock, 8 ns period.
    always #4 clock = ~clock;
    pmcs_switch #(.OST_CYC(OSC_STARTUP_TIMER)) u_pmcs_switch (
        .clock(clock), .nrst(nrst), .clock_select(clock_select),
        .idle_on_sleep(idle_on_sleep), .sleep_exec(sleep_exec), .wake_event(wake_event),
        .secondary_osc_enable(sec_bit), .sec_osc_running(secondary_run_mode), .pri_tick(pri_tick),
        .sec_tick(sec_tick), .int_tick(int_tick), .crystal_mode(crystal_mode),
        .two_speed_en(two_speed_en), .fscm_en(fscm_en), .wdt_en(wdt_en),
        .cpu_clk_tick(cpu_tick), .periph_clk_tick(per_tick), .active_src(active_src),
        .pri_osc_en(pri_en), .sec_osc_en(sec_en), .int_osc_en(int_en),
        .primary_clock_active(pact), .secondary_clock_active(sact), .osc_control_reg(oreg));
    pmcs_osc_model #(.SEC_START(SEC_ST)) u_pmcs_osc_model (
        .clock(clock), .nrst(nrst), .pri_en(pri_en), .sec_en(sec_bit), .int_en(int_en),
        .pri_tick(pri_tick), .sec_tick(sec_tick), .int_tick(int_tick), .secondary_run_mode(secondary_run_mode));
    ////////////////////////////////////////////////////////////////////////////////
    // Single place where the run ends.
    task automatic wrap_up();
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Case equality, so an unknown output never passes.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Inputs always move 1 ns after the rising edge.
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic pulse(input bit wake);
        if (wake) wake_event = 1'b1;
        else sleep_exec = 1'b1;
        step(1);
        wake_event = 1'b0;
        sleep_exec = 1'b0;
    endtask
    // Waits for {active_src, primary flag}; CPU ticks after the first two cycles are counted.
    task automatic wait_st(input logic [2:0] exp);
        n_cyc = 0;
        n_cpu = 0;
        while ({active_src, pact} !== exp && n_cyc < 400) begin
            step(1);
            n_cyc++;
            if (n_cyc > 2) n_cpu += 32'(cpu_tick);
        end
        if (n_cyc >= 400) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic count(input int n);
        n_cpu = 0;
        n_per = 0;
        repeat (n) begin
            step(1);
            n_cpu += 32'(cpu_tick);
            n_per += 32'(per_tick);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: one scenario after another on a single design instance.
    initial begin
        step(10);
        check({active_src, pri_en, pact, sact, int_en, sec_en}, 8'h58);
        check(oreg, 8'h08);
        nrst = 1'b1;
        step(3);
        check({active_src, pact}, 8'h05);
        // Secondary with its oscillator disabled must be left alone.
        clock_select = 2'h1;
        count(40);
        check({active_src, sact}, 8'h04);
        // Enabling it late: no clocks until it oscillates.
        sec_bit = 1'b1;
        wait_st(3'h2);
        check(n_cyc >= SEC_ST, 8'h01);
        check(n_cpu, 8'h00);
        check({pact, sact, pri_en}, 8'h02);
        check(oreg, 8'h01);
        // Back to primary: secondary keeps clocking through the crystal count.
        clock_select = 2'h2;
        wait_st(3'h5);
        check(n_cpu != 0, 8'h01);
        check(n_cyc >= 2 * OSC_STARTUP_TIMER, 8'h01);
        check({sact, sec_en}, 8'h01);
        // Primary to internal: two old plus four new ticks, fully gated.
        clock_select = 2'h3;
        wait_st(3'h6);
        check(n_cyc >= 20 && n_cyc <= 48, 8'h01);
        check(n_cpu, 8'h00);
        check({pact, sact, pri_en}, 8'h00);
        clock_select = 2'h2;
        wait_st(3'h5);
        check(n_cpu != 0, 8'h01);
        check({int_en, oreg}, 9'h10A);
        // Sleep: all clocks and flags drop, watchdog and secondary sources stay up.
        pulse(0);
        step(2);
        check({pact, sact, pri_en, int_en, sec_en}, 8'h03);
        count(24);
        check(n_cpu + n_per, 8'h00);
        pulse(1);
        wait_st(3'h5);
        check(n_cpu, 8'h00);
        check(oreg, 8'h0A);
        // Idle on primary: peripherals run, CPU stops, flags kept.
        step(4);
        idle_on_sleep = 1'b1;
        pulse(0);
        count(24);
        check({n_cpu == 0, n_per != 0, pact}, 8'h07);
        pulse(1);
        count(8);
        check(n_cpu != 0, 8'h01);
        // A second sleep honours the bit as it is now.
        idle_on_sleep = 1'b0;
        pulse(0);
        step(2);
        check(pact, 8'h00);
        // With the clock monitor on, wake runs from internal at once.
        fscm_en = 1'b1;
        pulse(1);
        wait_st(3'h6);
        check(n_cyc <= 2, 8'h01);
        wait_st(3'h5);
        check(oreg, 8'h0A);
        // A reset with two-speed start-up comes up on internal, then moves to primary.
        two_speed_en = 1'b1;
        nrst = 1'b0;
        step(2);
        nrst = 1'b1;
        step(1);
        check({active_src, pact, int_en}, 8'h0D);
        wait_st(3'h5);
        check(n_cpu != 0, 8'h01);
        wrap_up();
    end
endmodule
`default_nettype wire
